// [hdl/bir_pkg.sv]
// Purpose: constants for the bus-info / rom-mapping register bank
// Assumes: 32-bit aligned register words, byte addresses as printed
// Notes:   shared by the bank and its bench
//
// Behaviour
// - max request code in bits 15..12 means 2^(code+1) bytes, never below 512
// - max request code loads Ah (2048) on hardware reset, untouched by soft reset
// - block write longer than max request size may be answered type-error
// - reserved bus-options bits 11..8, 5..3 and map bits 9..0 read zero
// - generation counter bits 7..6 step at bus reset if rom changed since last
// - link speed bits 2..0 always read 010b
// - upper unique id is all zero after hardware reset, an invalid id
// - with eeprom present, unique ids load from eeprom, then never change
// - without eeprom, firmware loads unique ids, then device freezes them
// - unique id bits are reset by global reset only
// - lower unique id behaves exactly like the upper one
// - rom window quadlet read: host address is map base plus low ten bits
// - rom map register is read-write at 34h and clears to zero on reset
package bir_pkg;

  localparam logic [7:0]  OFF_BUS_OPT   = 8'h20;
  localparam logic [7:0]  OFF_UID_UP    = 8'h24;
  localparam logic [7:0]  OFF_UID_LO    = 8'h28;
  localparam logic [7:0]  OFF_ROM_MAP   = 8'h34;

  localparam int          MAXREC_HI     = 15;
  localparam int          MAXREC_LO     = 12;
  localparam int          GEN_HI        = 7;
  localparam int          GEN_LO        = 6;
  localparam int          MAP_BASE_LO   = 10;

  localparam logic [3:0]  MAXREC_RST    = 4'hA;
  localparam logic [3:0]  MAXREC_MIN    = 4'h8;
  localparam logic [1:0]  GEN_RST       = 2'h0;
  localparam logic [2:0]  LNK_SPD       = 3'h2;
  localparam logic [31:0] UID_RST       = 32'h0000_0000;
  localparam logic [31:0] ROM_MAP_RST   = 32'h0000_0000;
  localparam logic [31:0] ROM_MAP_MASK  = 32'hFFFF_FC00;

  localparam logic [47:0] ROM_WIN_LO    = 48'hFFFF_F000_0400;
  localparam logic [47:0] ROM_WIN_HI    = 48'hFFFF_F000_07FF;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

endpackage : bir_pkg

// [hdl/bir_regs.sv]
// Purpose: bus options (low half), unique id pair and rom map registers
// Assumes: srst_i is the global reset; soft_rst_i is the software reset
// Notes:   axi4-lite slave, one write and one read outstanding at a time
`timescale 1ns/100ps

module bir_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              srst_i,
  input  wire logic              soft_rst_i,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // serial eeprom loader
  input  wire logic              eeprom_present_i,
  input  wire logic              eeprom_wr_i,
  input  wire logic              eeprom_sel_lower_i,
  input  wire logic [31:0]       eeprom_data_i,
  // link events
  input  wire logic              rom_changed_i,
  input  wire logic              bus_reset_i,
  input  wire logic              blk_wr_valid_i,
  input  wire logic [15:0]       blk_wr_len_i,
  input  wire logic              rom_rd_valid_i,
  input  wire logic [47:0]       rom_rd_offset_i,
  // results
  output logic                   blk_wr_type_err_o,
  output logic                   host_addr_valid_o,
  output logic [31:0]            host_addr_o,
  output logic [31:0]            unique_id_upper_o,
  output logic [31:0]            unique_id_lower_o,
  output logic                   uid_upper_locked_o,
  output logic                   uid_lower_locked_o,
  output logic [3:0]             max_rec_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] word_of(input logic [ADDR_W-1:0] a);
    word_of = {a[7:2], 2'b00};
  endfunction

  function automatic logic is_mapped(input logic [7:0] w);
    is_mapped = (w == bir_pkg::OFF_BUS_OPT) || (w == bir_pkg::OFF_UID_UP) ||
                (w == bir_pkg::OFF_UID_LO) || (w == bir_pkg::OFF_ROM_MAP);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // 17 bits so that code Fh (64 KiB) does not wrap
  function automatic logic [16:0] max_bytes(input logic [3:0] code);
    max_bytes = 17'h1 << ({1'b0, code} + 5'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [3:0]  max_rec, next_max_rec;
  logic [1:0]  gen, next_gen;
  logic        rom_dirty, next_rom_dirty;
  logic [31:0] uid_up, next_uid_up;
  logic [31:0] uid_lo, next_uid_lo;
  logic        lock_up, next_lock_up;
  logic        lock_lo, next_lock_lo;
  logic [31:0] rom_map, next_rom_map;

  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        aw_held, next_aw_held;
  logic        w_held, next_w_held;
  logic        awready, next_awready;
  logic        wready, next_wready;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        arready, next_arready;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  logic [7:0]  rd_word, next_rd_word;

  logic        blk_err, next_blk_err;
  logic        ha_valid, next_ha_valid;
  logic [31:0] host_addr, next_host_addr;

  logic        wr_fire;
  logic [31:0] bus_opt_rd;

  assign wr_fire    = aw_held && w_held && !bvalid;
  assign bus_opt_rd = {16'h0000, max_rec, 4'h0, gen, 3'h0, bir_pkg::LNK_SPD};

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite channels

  always_comb begin
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_awready = awready;
    next_wready  = wready;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_arready = arready;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_rd_word = rd_word;
    if (s_axi_awvalid_i && awready) begin
      next_aw_addr = word_of(s_axi_awaddr_i);
      next_aw_held = 1'b1;
      next_awready = 1'b0;
    end
    if (s_axi_wvalid_i && wready) begin
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
      next_w_held = 1'b1;
      next_wready = 1'b0;
    end
    if (wr_fire) begin
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(aw_addr) ? bir_pkg::RESP_OKAY : bir_pkg::RESP_DECERR;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    // ready comes back only after the response, so only one write is in flight
    if (bvalid && s_axi_bready_i) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (s_axi_arvalid_i && arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rd_word = word_of(s_axi_araddr_i);
      next_rresp   = bir_pkg::RESP_OKAY;
      case (word_of(s_axi_araddr_i))
        bir_pkg::OFF_BUS_OPT: next_rdata = bus_opt_rd;
        bir_pkg::OFF_UID_UP:  next_rdata = uid_up;
        bir_pkg::OFF_UID_LO:  next_rdata = uid_lo;
        bir_pkg::OFF_ROM_MAP: next_rdata = rom_map & bir_pkg::ROM_MAP_MASK;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = bir_pkg::RESP_DECERR;
        end
      endcase
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= bir_pkg::RESP_OKAY;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= bir_pkg::RESP_OKAY;
      rd_word <= 8'h00;
    end else begin
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      rd_word <= next_rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank

  always_comb begin
    logic [31:0] m;
    m              = 32'h0000_0000;
    next_max_rec   = max_rec;
    next_gen       = gen;
    next_rom_dirty = rom_dirty;
    next_uid_up    = uid_up;
    next_uid_lo    = uid_lo;
    next_lock_up   = lock_up;
    next_lock_lo   = lock_lo;
    next_rom_map   = rom_map;
    if (wr_fire && aw_addr == bir_pkg::OFF_BUS_OPT) begin
      m = merge(bus_opt_rd, w_data, w_strb);
      // codes below 512 bytes are dropped so the field always stays legal
      if (m[bir_pkg::MAXREC_HI:bir_pkg::MAXREC_LO] >= bir_pkg::MAXREC_MIN) begin
        next_max_rec = m[bir_pkg::MAXREC_HI:bir_pkg::MAXREC_LO];
      end
      next_gen = m[bir_pkg::GEN_HI:bir_pkg::GEN_LO];
    end
    if (eeprom_present_i) begin
      if (eeprom_wr_i && !eeprom_sel_lower_i && !lock_up) begin
        next_uid_up  = eeprom_data_i;
        next_lock_up = 1'b1;
      end
      if (eeprom_wr_i && eeprom_sel_lower_i && !lock_lo) begin
        next_uid_lo  = eeprom_data_i;
        next_lock_lo = 1'b1;
      end
    end else if (wr_fire) begin
      if (aw_addr == bir_pkg::OFF_UID_UP && !lock_up) begin
        next_uid_up  = merge(uid_up, w_data, w_strb);
        next_lock_up = 1'b1;
      end
      if (aw_addr == bir_pkg::OFF_UID_LO && !lock_lo) begin
        next_uid_lo  = merge(uid_lo, w_data, w_strb);
        next_lock_lo = 1'b1;
      end
    end
    if (soft_rst_i) begin
      next_rom_map = bir_pkg::ROM_MAP_RST;
    end else if (wr_fire && aw_addr == bir_pkg::OFF_ROM_MAP) begin
      next_rom_map = merge(rom_map, w_data, w_strb) & bir_pkg::ROM_MAP_MASK;
    end
    // a change in the bus-reset cycle is folded into that step, not lost
    if (bus_reset_i) begin
      next_rom_dirty = 1'b0;
      if (rom_dirty || rom_changed_i) begin
        next_gen = gen + 2'h1;
      end
    end else if (rom_changed_i) begin
      next_rom_dirty = 1'b1;
    end
  end

  // only the global reset reaches the id pair and max request code
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      max_rec   <= bir_pkg::MAXREC_RST;
      gen       <= bir_pkg::GEN_RST;
      rom_dirty <= 1'b0;
      uid_up    <= bir_pkg::UID_RST;
      uid_lo    <= bir_pkg::UID_RST;
      lock_up   <= 1'b0;
      lock_lo   <= 1'b0;
      rom_map   <= bir_pkg::ROM_MAP_RST;
    end else begin
      max_rec   <= next_max_rec;
      gen       <= next_gen;
      rom_dirty <= next_rom_dirty;
      uid_up    <= next_uid_up;
      uid_lo    <= next_uid_lo;
      lock_up   <= next_lock_up;
      lock_lo   <= next_lock_lo;
      rom_map   <= next_rom_map;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link request checks

  always_comb begin
    next_blk_err   = blk_wr_valid_i && ({1'b0, blk_wr_len_i} > max_bytes(max_rec));
    next_ha_valid  = rom_rd_valid_i && (rom_rd_offset_i >= bir_pkg::ROM_WIN_LO) &&
                     (rom_rd_offset_i <= bir_pkg::ROM_WIN_HI);
    next_host_addr = host_addr;
    if (next_ha_valid) begin
      next_host_addr = (rom_map & bir_pkg::ROM_MAP_MASK) + {22'h0, rom_rd_offset_i[9:0]};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      blk_err   <= 1'b0;
      ha_valid  <= 1'b0;
      host_addr <= 32'h0000_0000;
    end else begin
      blk_err   <= next_blk_err;
      ha_valid  <= next_ha_valid;
      host_addr <= next_host_addr;
    end
  end

  assign s_axi_awready_o    = awready;
  assign s_axi_wready_o     = wready;
  assign s_axi_bvalid_o     = bvalid;
  assign s_axi_bresp_o      = bresp;
  assign s_axi_arready_o    = arready;
  assign s_axi_rvalid_o     = rvalid;
  assign s_axi_rdata_o      = rdata;
  assign s_axi_rresp_o      = rresp;
  assign blk_wr_type_err_o  = blk_err;
  assign host_addr_valid_o  = ha_valid;
  assign host_addr_o        = host_addr;
  assign unique_id_upper_o  = uid_up;
  assign unique_id_lower_o  = uid_lo;
  assign uid_upper_locked_o = lock_up;
  assign uid_lower_locked_o = lock_lo;
  assign max_rec_o          = max_rec;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_maxrec_min;
    @(posedge mclk_i) disable iff (srst_i) max_rec >= 4'h8;
  endproperty
  a_maxrec_min: assert property (p_maxrec_min) else $error("max request below 512");

  property p_maxrec_rst;
    @(posedge mclk_i) $past(srst_i) |-> (max_rec == 4'hA);
  endproperty
  a_maxrec_rst: assert property (p_maxrec_rst) else $error("max request not Ah after reset");

  property p_maxrec_only_wr;
    @(posedge mclk_i) disable iff (srst_i)
      !$stable(max_rec) |-> $past(wr_fire && aw_addr == bir_pkg::OFF_BUS_OPT);
  endproperty
  a_maxrec_only_wr: assert property (p_maxrec_only_wr) else $error("max request changed without write");

  property p_blk_err;
    @(posedge mclk_i) disable iff (srst_i)
      blk_wr_valid_i |=> (blk_wr_type_err_o == ($past({1'b0, blk_wr_len_i}) > (17'h1 << ($past(max_rec) + 5'h1))));
  endproperty
  a_blk_err: assert property (p_blk_err) else $error("type error flag wrong");

  property p_rsvd_zero;
    @(posedge mclk_i) disable iff (srst_i)
      s_axi_rvalid_o && s_axi_rresp_o == 2'h0 && rd_word == 8'h20 |->
        s_axi_rdata_o[11:8] == 4'h0 && s_axi_rdata_o[5:3] == 3'h0 && s_axi_rdata_o[2:0] == 3'h2;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("bus options reserved or speed bits wrong");

  property p_map_rsvd;
    @(posedge mclk_i) disable iff (srst_i)
      s_axi_rvalid_o && rd_word == 8'h34 |-> s_axi_rdata_o[9:0] == 10'h000;
  endproperty
  a_map_rsvd: assert property (p_map_rsvd) else $error("map reserved bits nonzero");

  property p_gen_step;
    @(posedge mclk_i) disable iff (srst_i)
      bus_reset_i && (rom_dirty || rom_changed_i) && !wr_fire |=> gen == $past(gen) + 2'h1;
  endproperty
  a_gen_step: assert property (p_gen_step) else $error("generation not stepped");

  property p_uid_frozen;
    @(posedge mclk_i) disable iff (srst_i)
      lock_up |=> lock_up && $stable(uid_up);
  endproperty
  a_uid_frozen: assert property (p_uid_frozen) else $error("locked upper unique id changed");

  property p_uid_lo_frozen;
    @(posedge mclk_i) disable iff (srst_i)
      lock_lo |=> lock_lo && $stable(uid_lo);
  endproperty
  a_uid_lo_frozen: assert property (p_uid_lo_frozen) else $error("locked lower unique id changed");

  property p_uid_rst;
    @(posedge mclk_i) $past(srst_i) |-> uid_up == 32'h0 && uid_lo == 32'h0 && !lock_up && !lock_lo;
  endproperty
  a_uid_rst: assert property (p_uid_rst) else $error("unique id not clear after reset");

  property p_host_addr;
    @(posedge mclk_i) disable iff (srst_i)
      rom_rd_valid_i && rom_rd_offset_i >= 48'hFFFF_F000_0400 && rom_rd_offset_i <= 48'hFFFF_F000_07FF |=>
        host_addr_valid_o && host_addr_o == (($past(rom_map) & 32'hFFFF_FC00) + {22'h0, $past(rom_rd_offset_i[9:0])});
  endproperty
  a_host_addr: assert property (p_host_addr) else $error("host address wrong");

  property p_map_soft;
    @(posedge mclk_i) disable iff (srst_i)
      soft_rst_i |=> rom_map == 32'h0 && ($stable(max_rec) || $past(wr_fire));
  endproperty
  a_map_soft: assert property (p_map_soft) else $error("soft reset effect wrong");

endmodule // bir_regs

// [verification/bir_eeprom_model.sv]
// Purpose: serial eeprom loader standing in front of the unique id pair
// Assumes: one 32-bit word per load pulse; sel picks the lower quadlet
// Notes:   after a load the data line shows the inverse word, never a stale copy
`timescale 1ns/100ps

module bir_eeprom_model (
  input  wire logic        mclk_i,
  output logic             present_o,
  output logic             wr_o,
  output logic             sel_lower_o,
  output logic [31:0]      data_o
);
  initial begin
    present_o   = 1'b0;
    wr_o        = 1'b0;
    sel_lower_o = 1'b0;
    data_o      = 32'h5A5A_A5A5;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic set_present(input logic p);
    @(posedge mclk_i);
    present_o <= p;
  endtask

  // one word per pulse, then the line is released
  task automatic load(input logic sel, input logic [31:0] d);
    @(posedge mclk_i);
    wr_o        <= 1'b1;
    sel_lower_o <= sel;
    data_o      <= d;
    @(posedge mclk_i);
    wr_o        <= 1'b0;
    data_o      <= ~d;
  endtask
endmodule // bir_eeprom_model

// [verification/bir_regs_bench.sv]
// Purpose: self-checking bench for the bus-info / rom-mapping register bank
// Assumes: axi4-lite master tasks, link events driven as one-cycle pulses
// Notes:   waits are bounded; a stuck handshake ends the run
`timescale 1ns/100ps

module bir_regs_bench;
  logic        mclk_i, srst_i, soft_rst_i;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, host_addr;
  logic [3:0]  wstrb, max_rec;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        e_pres, e_wr, e_sel, chg, brst, blk_v, rom_v, type_err, ha_v;
  logic [31:0] e_data, uid_up, uid_lo;
  logic        lk_up, lk_lo;
  logic [15:0] blk_len;
  logic [47:0] rom_off;
  int          err_total, n_compared, k;

  bir_regs #(.ADDR_W(8)) u_bir_regs (
    .mclk_i(mclk_i), .srst_i(srst_i), .soft_rst_i(soft_rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .eeprom_present_i(e_pres), .eeprom_wr_i(e_wr), .eeprom_sel_lower_i(e_sel), .eeprom_data_i(e_data),
    .rom_changed_i(chg), .bus_reset_i(brst), .blk_wr_valid_i(blk_v), .blk_wr_len_i(blk_len),
    .rom_rd_valid_i(rom_v), .rom_rd_offset_i(rom_off), .blk_wr_type_err_o(type_err),
    .host_addr_valid_o(ha_v), .host_addr_o(host_addr), .unique_id_upper_o(uid_up),
    .unique_id_lower_o(uid_lo), .uid_upper_locked_o(lk_up), .uid_lower_locked_o(lk_lo),
    .max_rec_o(max_rec)
  );

  bir_eeprom_model u_bir_eeprom_model (
    .mclk_i(mclk_i), .present_o(e_pres), .wr_o(e_wr), .sel_lower_o(e_sel), .data_o(e_data)
  );

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic stuck(input int i);
    if (i >= 20) begin
      err_total++;
      $display("BAD %0t handshake timeout", $time);
      print_verdict();
    end
  endtask

  // master holds each channel until its own ready edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge mclk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    stuck(i);
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    @(posedge mclk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    stuck(i);
    chk(rdata, e, "rdata");
    chk({30'h0, rresp}, {30'h0, er}, "rresp");
  endtask

  // one-cycle link request; result pulse is due one cycle later
  task automatic link(input logic rom, input logic [47:0] off, input logic [15:0] len,
                      input logic ev, input logic [31:0] ea);
    @(posedge mclk_i);
    rom_v   <= rom;
    blk_v   <= ~rom;
    rom_off <= off;
    blk_len <= len;
    @(posedge mclk_i);
    rom_v   <= 1'b0;
    blk_v   <= 1'b0;
    #1;
    chk({31'h0, rom ? ha_v : type_err}, {31'h0, ev}, "link pulse");
    if (rom && ev) chk(host_addr, ea, "host addr");
  endtask

  task automatic pulse(input logic c, input logic b, input logic s, input logic g);
    @(posedge mclk_i);
    chg        <= c;
    brst       <= b;
    soft_rst_i <= s;
    srst_i     <= g;
    repeat (g ? 2 : 1) @(posedge mclk_i);
    {chg, brst, soft_rst_i, srst_i} <= 4'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    n_compared = 0;
    {srst_i, soft_rst_i, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {chg, brst, blk_v, rom_v} = 4'h0;
    {awaddr, araddr, wdata, wstrb, blk_len, rom_off} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(bir_pkg::OFF_BUS_OPT, 32'h0000_A002, bir_pkg::RESP_OKAY);
    chk({28'h0, max_rec}, 32'hA, "max rec");
    rd(bir_pkg::OFF_UID_UP, 32'h0, bir_pkg::RESP_OKAY);
    rd(bir_pkg::OFF_UID_LO, 32'h0, bir_pkg::RESP_OKAY);
    rd(bir_pkg::OFF_ROM_MAP, 32'h0, bir_pkg::RESP_OKAY);
    rd(8'h00, 32'h0, bir_pkg::RESP_DECERR);
    wr(8'h3C, 32'h1, bir_pkg::RESP_DECERR);
    wr(bir_pkg::OFF_ROM_MAP, 32'hFFFF_FFFF, bir_pkg::RESP_OKAY);
    rd(bir_pkg::OFF_ROM_MAP, 32'hFFFF_FC00, bir_pkg::RESP_OKAY);
    wr(bir_pkg::OFF_ROM_MAP, 32'h1234_5678, bir_pkg::RESP_OKAY);
    link(1'b1, 48'hFFFF_F000_0400, 16'h0, 1'b1, 32'h1234_5400);
    link(1'b1, 48'hFFFF_F000_07FF, 16'h0, 1'b1, 32'h1234_57FF);
    link(1'b1, 48'hFFFF_F000_0800, 16'h0, 1'b0, 32'h0);
    link(1'b1, 48'hFFFF_F000_03FC, 16'h0, 1'b0, 32'h0);
    // a single byte lane must merge into the held word
    wstrb <= 4'h2;
    wr(bir_pkg::OFF_ROM_MAP, 32'hAAAA_AAAA, bir_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd(bir_pkg::OFF_ROM_MAP, 32'h1234_A800, bir_pkg::RESP_OKAY);
    // reserved bits written as ones must still read zero
    wr(bir_pkg::OFF_BUS_OPT, 32'h0000_9F38, bir_pkg::RESP_OKAY);
    rd(bir_pkg::OFF_BUS_OPT, 32'h0000_9002, bir_pkg::RESP_OKAY);
    link(1'b0, 48'h0, 16'd1024, 1'b0, 32'h0);
    link(1'b0, 48'h0, 16'd1025, 1'b1, 32'h0);
    wr(bir_pkg::OFF_BUS_OPT, 32'h0000_7002, bir_pkg::RESP_OKAY);
    rd(bir_pkg::OFF_BUS_OPT, 32'h0000_9002, bir_pkg::RESP_OKAY);
    wr(bir_pkg::OFF_BUS_OPT, 32'h0000_8002, bir_pkg::RESP_OKAY);
    link(1'b0, 48'h0, 16'd512, 1'b0, 32'h0);
    link(1'b0, 48'h0, 16'd513, 1'b1, 32'h0);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    rd(bir_pkg::OFF_ROM_MAP, 32'h0, bir_pkg::RESP_OKAY);
    chk({28'h0, max_rec}, 32'h8, "max rec soft");
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    rd(bir_pkg::OFF_BUS_OPT, 32'h0000_8002, bir_pkg::RESP_OKAY);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    rd(bir_pkg::OFF_BUS_OPT, 32'h0000_8042, bir_pkg::RESP_OKAY);
    pulse(1'b1, 1'b1, 1'b0, 1'b0);
    rd(bir_pkg::OFF_BUS_OPT, 32'h0000_8082, bir_pkg::RESP_OKAY);
    // firmware load, then the frozen word refuses a rewrite
    for (k = 0; k < 2; k++) begin
      wr(k ? bir_pkg::OFF_UID_LO : bir_pkg::OFF_UID_UP, 32'hCAFE_0001 + k, bir_pkg::RESP_OKAY);
      wr(k ? bir_pkg::OFF_UID_LO : bir_pkg::OFF_UID_UP, 32'h1111_1111, bir_pkg::RESP_OKAY);
      rd(k ? bir_pkg::OFF_UID_LO : bir_pkg::OFF_UID_UP, 32'hCAFE_0001 + k, bir_pkg::RESP_OKAY);
    end
    chk({30'h0, lk_up, lk_lo}, 32'h3, "locks");
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    chk(uid_up, 32'hCAFE_0001, "upper id after soft reset");
    chk(uid_lo, 32'hCAFE_0002, "lower id after soft reset");
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    chk(uid_up | uid_lo, 32'h0, "ids after global reset");
    chk({30'h0, lk_up, lk_lo}, 32'h0, "locks after global reset");
    rd(bir_pkg::OFF_BUS_OPT, 32'h0000_A002, bir_pkg::RESP_OKAY);
    u_bir_eeprom_model.set_present(1'b1);
    wr(bir_pkg::OFF_UID_UP, 32'h2222_2222, bir_pkg::RESP_OKAY);
    rd(bir_pkg::OFF_UID_UP, 32'h0, bir_pkg::RESP_OKAY);
    u_bir_eeprom_model.load(1'b0, 32'hA5A5_0F0F);
    u_bir_eeprom_model.load(1'b1, 32'h0F0F_A5A5);
    u_bir_eeprom_model.load(1'b0, 32'h0);
    rd(bir_pkg::OFF_UID_UP, 32'hA5A5_0F0F, bir_pkg::RESP_OKAY);
    rd(bir_pkg::OFF_UID_LO, 32'h0F0F_A5A5, bir_pkg::RESP_OKAY);
    print_verdict();
  end
endmodule // bir_regs_bench
